//--- hdl/bmsl_loader.sv
`timescale 1ns/1ps
`include "bmsl_consts.svh"

// What this block does
// - boot serial clock is master clock over 256
// - supply good starts exactly 256 bit load
// - clock keeps running, data ignored after load
// - bit 0 picks block read ordering
// - bit 1 check mode, bit 2 endianness
// - bit 3 disables dirty shared transition
// - bit 4 set means no secondary cache
// - bits 9-10 give line size 4..32 words
// - bits 11-14 give transmit data pattern
// - bits 15-17 give system clock divisor
// - bit 19 turns timer interrupt general purpose
// - bit 20 suppresses potential invalidates
// - bits 21-24 write deassertion delay
// - bits 25-28 two write assertion delays
// - bit 29 write recovery zero or one
// - bits 30-32 secondary cache disable time
// - bits 33-40 two read cycle times
// - bit 41 keeps line valid after miss
// - bit 42 with master pin picks role
// - bits 47-49 reduced power clock divisor
// - clock driven out, data on own pin
module bmsl_loader (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        supply_good_in,
    input  wire logic        boot_serial_data_in,
    input  wire logic        interface_master_role,
    output logic             boot_serial_clk_out,
    output logic             config_done,
    output logic             block_read_ordering,
    output logic             check_bus_mode,
    output logic             byte_order_sel,
    output logic             dirty_shared_disable,
    output logic             no_secondary_cache,
    output logic [5:0]       l2_line_size,
    output logic [3:0]       transmit_data_pattern,
    output logic [3:0]       sys_clock_divisor,
    output logic             timer_irq_disable,
    output logic             potential_invalidate_disable,
    output logic [3:0]       l2_write_deassert_delay,
    output logic [1:0]       l2_write_assert_delay_b,
    output logic [1:0]       l2_write_assert_delay_a,
    output logic             l2_write_recovery,
    output logic [2:0]       l2_disable_time,
    output logic [3:0]       l2_read_cycle_time,
    output logic [3:0]       l2_read_cycle_time_a,
    output logic             keep_line_on_miss,
    output logic             complete_master,
    output logic             complete_listener,
    output logic [3:0]       pipeline_clk_divisor,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // All state of the block in one record
    typedef struct packed {
        bmsl_pkg::bmsl_state_t st;          // Loader sequence state
        logic [7:0]            div_cnt;     // Boot clock divider phase
        logic                  clk_out;     // Boot clock pin level
        logic [8:0]            bit_cnt;     // Bits taken so far
        logic [255:0]          cfg;         // Captured mode stream
        logic                  done;        // Stream complete
        logic                  sg_meta;     // Supply good, first stage
        logic                  sg_sync;     // Supply good, second stage
        logic                  sg_prev;     // For rising edge
        logic                  din_meta;    // Serial data, first stage
        logic                  din_sync;    // Serial data, second stage
        logic                  im_meta;     // Master pin, first stage
        logic                  im_sync;     // Master pin, second stage
        logic                  rpower;      // Reduced power flag
        logic [5:0]            line_words;  // Decoded line size
        logic [3:0]            sys_div;     // Decoded system divisor
        logic [3:0]            pipe_div;    // Effective pipeline divisor
        logic                  role_master; // Complete master
        logic                  role_listen; // Complete listener
        logic                  aw_pend;     // Write address held
        logic [11:0]           aw_addr;     // Held write address
        logic                  w_pend;      // Write data held
        logic [31:0]           w_data;      // Held write data
        logic [3:0]            w_strb;      // Held byte enables
        logic                  aw_rdy;      // Address channel ready
        logic                  w_rdy;       // Data channel ready
        logic                  bvalid;      // Write response valid
        logic [1:0]            bresp;       // Write response code
        logic                  ar_rdy;      // Read address ready
        logic                  rvalid;      // Read data valid
        logic [31:0]           rdata;       // Read data
        logic [1:0]            rresp;       // Read response code
    } bmsl_regs_t;

    bmsl_regs_t s_q;   // Registered state
    bmsl_regs_t s_d;   // Next state

    // Next state of everything
    always_comb begin
        logic        sg_rise;   // Supply good just came up
        logic        reload;    // Software restart request
        logic        rd_hit;    // Read address decodes
        logic        wr_hit;    // Write address decodes
        logic [2:0]  widx;      // Config word index for reads
        s_d     = s_q;
        sg_rise = 1'b0;
        reload  = 1'b0;
        rd_hit  = 1'b0;
        wr_hit  = 1'b0;
        widx    = 3'h0;

        // Pins cross into the clock domain through two flops
        s_d.sg_meta  = supply_good_in;
        s_d.sg_sync  = s_q.sg_meta;
        s_d.din_meta = boot_serial_data_in;
        s_d.din_sync = s_q.din_meta;
        s_d.im_meta  = interface_master_role;
        s_d.im_sync  = s_q.im_meta;
        s_d.sg_prev  = s_q.sg_sync;
        sg_rise      = s_q.sg_sync && !s_q.sg_prev;

        // Free running divider; the pin is high for the upper half
        s_d.div_cnt = s_q.div_cnt + 8'h01;
        s_d.clk_out = s_d.div_cnt[7];

        // Bus write: both halves held and no response pending
        if (s_q.aw_pend && s_q.w_pend && !s_q.bvalid) begin
            wr_hit     = (s_q.aw_addr[11:2] == `BMSL_OFS_CTRL >> 2);
            s_d.bvalid = 1'b1;
            s_d.bresp  = wr_hit ? `BMSL_RESP_OKAY : `BMSL_RESP_SLVERR;
            s_d.aw_pend = 1'b0;
            s_d.w_pend  = 1'b0;
            if (wr_hit && s_q.w_strb[0]) begin
                reload     = s_q.w_data[`BMSL_CTRL_RELOAD];
                s_d.rpower = s_q.w_data[`BMSL_CTRL_RPOWER];
            end
        end

        // Loader sequence
        case (s_q.st)
            bmsl_pkg::BMSL_IDLE: begin
                // Supply coming good starts the stream at once
                if (sg_rise || (reload && s_q.sg_sync)) begin
                    s_d.st      = bmsl_pkg::BMSL_LOAD;
                    s_d.bit_cnt = 9'h000;
                    s_d.div_cnt = 8'h00;
                    s_d.clk_out = 1'b0;
                    s_d.done    = 1'b0;
                end
            end
            bmsl_pkg::BMSL_LOAD: begin
                // One bit per period, lowest number first
                if (s_q.div_cnt == `BMSL_SAMPLE_PHASE) begin
                    s_d.cfg[s_q.bit_cnt[7:0]] = s_q.din_sync;
                    s_d.bit_cnt = s_q.bit_cnt + 9'h001;
                    if (s_q.bit_cnt == `BMSL_LAST_BIT) begin
                        s_d.st   = bmsl_pkg::BMSL_DONE;
                        s_d.done = 1'b1;
                    end
                end
            end
            bmsl_pkg::BMSL_DONE: begin
                // Data pin is no longer looked at; only a reload restarts
                if (reload && s_q.sg_sync) begin
                    s_d.st      = bmsl_pkg::BMSL_LOAD;
                    s_d.bit_cnt = 9'h000;
                    s_d.div_cnt = 8'h00;
                    s_d.clk_out = 1'b0;
                    s_d.done    = 1'b0;
                end
            end
            default: begin
                s_d.st = bmsl_pkg::BMSL_IDLE;
            end
        endcase

        // Losing the supply abandons the load; modes stay as captured
        if (!s_q.sg_sync) begin
            s_d.st   = bmsl_pkg::BMSL_IDLE;
            s_d.done = 1'b0;
        end

        // Line size doubles per code step from four words
        s_d.line_words = 6'h04 << s_q.cfg[`BMSL_B_LINE +: 2];

        // System clock divisor; reserved codes fall back to two
        case (s_q.cfg[`BMSL_B_SYSDIV +: 3])
            3'h0:    s_d.sys_div = 4'h2;
            3'h1:    s_d.sys_div = 4'h3;
            3'h2:    s_d.sys_div = 4'h4;
            3'h3:    s_d.sys_div = 4'h6;
            3'h4:    s_d.sys_div = 4'h8;
            default: s_d.sys_div = 4'h2;
        endcase

        // Reduced power divisor applies only while the flag is set
        if (!s_q.rpower) begin
            s_d.pipe_div = 4'h1;
        end else begin
            case (s_q.cfg[`BMSL_B_LPDIV +: 3])
                3'h0:    s_d.pipe_div = 4'h2;
                3'h1:    s_d.pipe_div = 4'h4;
                3'h2:    s_d.pipe_div = 4'h8;
                default: s_d.pipe_div = 4'h2;
            endcase
        end

        // Role comes from the stream bit together with the master pin
        s_d.role_master = !s_q.cfg[`BMSL_B_L2MASTER] && !s_q.im_sync;
        s_d.role_listen = s_q.cfg[`BMSL_B_L2MASTER] && s_q.im_sync;

        // Write response retires on bready
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // Address and data are taken independently, in either order
        if (s_axi_awvalid && s_q.aw_rdy) begin
            s_d.aw_pend = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.w_rdy) begin
            s_d.w_pend = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        s_d.aw_rdy = !s_d.aw_pend && !s_d.bvalid;
        s_d.w_rdy  = !s_d.w_pend && !s_d.bvalid;

        // Read: answer on the edge after the address is taken
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.ar_rdy) begin
            rd_hit     = 1'b1;
            s_d.rvalid = 1'b1;
            s_d.rdata  = 32'h0000_0000;
            widx       = 3'(s_axi_araddr[4:2] - 3'h4);
            if (s_axi_araddr[11:2] == `BMSL_OFS_CTRL >> 2) begin
                s_d.rdata[`BMSL_CTRL_RPOWER] = s_q.rpower;
            end else if (s_axi_araddr[11:2] == `BMSL_OFS_STATUS >> 2) begin
                s_d.rdata = {20'h0_0000, s_q.im_sync, s_q.st == bmsl_pkg::BMSL_LOAD,
                             s_q.done, s_q.bit_cnt};
            end else if (s_axi_araddr[11:2] == `BMSL_OFS_DIVS >> 2) begin
                s_d.rdata = {18'h0_0000, s_q.line_words, s_q.sys_div, s_q.pipe_div};
            end else if (s_axi_araddr[11:2] >= `BMSL_OFS_CFG0 >> 2 &&
                         s_axi_araddr[11:2] <= `BMSL_OFS_CFG7 >> 2) begin
                s_d.rdata = s_q.cfg[{widx, 5'h00} +: 32];
            end else begin
                rd_hit = 1'b0;
            end
            s_d.rresp = rd_hit ? `BMSL_RESP_OKAY : `BMSL_RESP_SLVERR;
        end
        s_d.ar_rdy = !s_d.rvalid;
    end

    // One register for the whole record
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the record
    assign boot_serial_clk_out          = s_q.clk_out;
    assign config_done                  = s_q.done;
    assign block_read_ordering          = s_q.cfg[`BMSL_B_ORDER];
    assign check_bus_mode               = s_q.cfg[`BMSL_B_CHECK];
    assign byte_order_sel               = s_q.cfg[`BMSL_B_ENDIAN];
    assign dirty_shared_disable         = s_q.cfg[`BMSL_B_DSHARED];
    assign no_secondary_cache           = s_q.cfg[`BMSL_B_NOL2];
    assign l2_line_size                 = s_q.line_words;
    assign transmit_data_pattern        = s_q.cfg[`BMSL_B_XMIT +: 4];
    assign sys_clock_divisor            = s_q.sys_div;
    assign timer_irq_disable            = s_q.cfg[`BMSL_B_TIMER];
    assign potential_invalidate_disable = s_q.cfg[`BMSL_B_POTINV];
    assign l2_write_deassert_delay      = s_q.cfg[`BMSL_B_WRDEASS +: 4];
    assign l2_write_assert_delay_b      = s_q.cfg[`BMSL_B_WRASSB +: 2];
    assign l2_write_assert_delay_a      = s_q.cfg[`BMSL_B_WRASSA +: 2];
    assign l2_write_recovery            = s_q.cfg[`BMSL_B_WRREC];
    assign l2_disable_time              = s_q.cfg[`BMSL_B_DISTIME +: 3];
    assign l2_read_cycle_time           = s_q.cfg[`BMSL_B_RDCYC2 +: 4];
    assign l2_read_cycle_time_a         = s_q.cfg[`BMSL_B_RDCYC1 +: 4];
    assign keep_line_on_miss            = s_q.cfg[`BMSL_B_KEEPLINE];
    assign complete_master              = s_q.role_master;
    assign complete_listener            = s_q.role_listen;
    assign pipeline_clk_divisor         = s_q.pipe_div;
    assign s_axi_awready                = s_q.aw_rdy;
    assign s_axi_wready                 = s_q.w_rdy;
    assign s_axi_bvalid                 = s_q.bvalid;
    assign s_axi_bresp                  = s_q.bresp;
    assign s_axi_arready                = s_q.ar_rdy;
    assign s_axi_rvalid                 = s_q.rvalid;
    assign s_axi_rdata                  = s_q.rdata;
    assign s_axi_rresp                  = s_q.rresp;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Boot clock pin rise and the pin level held high for 8 cycles starting with the rise cycle
    sequence seq_clk_rise;
        $rose(boot_serial_clk_out);
    endsequence
    sequence seq_clk_high_half;
        boot_serial_clk_out [*8];
    endsequence

    chk_clk_period: assert property (
        (s_q.st != bmsl_pkg::BMSL_IDLE && s_q.div_cnt == 8'h7F) |=>
            ##256 $rose(boot_serial_clk_out))
        else $error("boot clock period is not 256 cycles");

    chk_clk_high: assert property (seq_clk_rise |-> seq_clk_high_half)
        else $error("boot clock high phase too short");

    chk_load_start: assert property (
        (s_q.st == bmsl_pkg::BMSL_IDLE && s_q.sg_sync && !s_q.sg_prev) |=>
            s_q.st == bmsl_pkg::BMSL_LOAD && s_q.bit_cnt == 9'h000)
        else $error("load did not start on supply good");

    chk_load_count: assert property (
        $rose(config_done) |-> s_q.bit_cnt == 9'h100)
        else $error("load ended without 256 bits");

    chk_cfg_frozen: assert property (
        (s_q.st == bmsl_pkg::BMSL_DONE && s_d.st == bmsl_pkg::BMSL_DONE) |=>
            $stable(s_q.cfg))
        else $error("mode bits changed after load");

    chk_clk_runs: assert property (
        (config_done && s_q.div_cnt == 8'h7F) |=> boot_serial_clk_out)
        else $error("boot clock stopped after load");

    chk_bit_capture: assert property (
        (s_q.st == bmsl_pkg::BMSL_LOAD && s_q.div_cnt == `BMSL_SAMPLE_PHASE) |=>
            s_q.cfg[$past(s_q.bit_cnt[7:0])] == $past(s_q.din_sync)
            && s_q.bit_cnt == $past(s_q.bit_cnt) + 9'h001)
        else $error("serial bit not stored in order");

    chk_role_master: assert property (
        (!s_q.cfg[`BMSL_B_L2MASTER] && !s_q.im_sync) |=> complete_master
            && !complete_listener)
        else $error("complete master role not selected");

    chk_lp_div: assert property (
        (s_q.rpower && s_q.cfg[`BMSL_B_LPDIV +: 3] == 3'h2) |=>
            pipeline_clk_divisor == 4'h8)
        else $error("reduced power divisor wrong");

    chk_sys_div: assert property (
        (s_q.cfg[`BMSL_B_SYSDIV +: 3] == 3'h3) |=> sys_clock_divisor == 4'h6)
        else $error("system clock divisor wrong");

endmodule

//--- hdl/bmsl_consts.svh
`ifndef BMSL_CONSTS_SVH
`define BMSL_CONSTS_SVH

// Serial stream length and boot clock divider
`define BMSL_STREAM_BITS   256
`define BMSL_CLK_DIVIDE    256
`define BMSL_LAST_BIT      9'h0FF
`define BMSL_SAMPLE_PHASE  8'h82

// Register byte offsets
`define BMSL_OFS_CTRL      12'h000
`define BMSL_OFS_STATUS    12'h004
`define BMSL_OFS_DIVS      12'h008
`define BMSL_OFS_CFG0      12'h010
`define BMSL_OFS_CFG7      12'h02C

// Control register fields
`define BMSL_CTRL_RELOAD   0
`define BMSL_CTRL_RPOWER   1

// Serial bit positions of the mode fields
`define BMSL_B_ORDER       0
`define BMSL_B_CHECK       1
`define BMSL_B_ENDIAN      2
`define BMSL_B_DSHARED     3
`define BMSL_B_NOL2        4
`define BMSL_B_LINE        9
`define BMSL_B_XMIT        11
`define BMSL_B_SYSDIV      15
`define BMSL_B_TIMER       19
`define BMSL_B_POTINV      20
`define BMSL_B_WRDEASS     21
`define BMSL_B_WRASSB      25
`define BMSL_B_WRASSA      27
`define BMSL_B_WRREC       29
`define BMSL_B_DISTIME     30
`define BMSL_B_RDCYC2      33
`define BMSL_B_RDCYC1      37
`define BMSL_B_KEEPLINE    41
`define BMSL_B_L2MASTER    42
`define BMSL_B_LPDIV       47

// AXI responses
`define BMSL_RESP_OKAY     2'h0
`define BMSL_RESP_SLVERR   2'h2

`endif

//--- hdl/bmsl_pkg.sv
package bmsl_pkg;

    // Loader sequence
    typedef enum logic [1:0] {
        BMSL_IDLE,
        BMSL_LOAD,
        BMSL_DONE
    } bmsl_state_t;

endpackage

//--- sim/bmsl_serial_mem.sv
`timescale 1ns/1ps

// Serial configuration memory behind the loader's boot pins
module bmsl_serial_mem (
    input  wire logic         serial_clk, // Boot serial clock from the loader
    input  wire logic         select,     // Supply good, restarts the stream
    input  wire logic [255:0] image,      // Stored configuration bits
    output logic              data_out    // Serial data towards the loader
);
    int unsigned idx;   // Index of the bit on the line
    logic        armed; // A rising edge was seen since the restart

    // Idle line at time zero
    initial begin
        idx = 0;
        armed = 1'b0;
        data_out = 1'b0;
    end

    // Restart puts bit 0 on the line well before the first sampling edge
    always @(posedge select) begin
        idx = 0;
        armed = 1'b0;
        data_out <= image[0];
    end

    // Released line shows the inverse, so a stale bit cannot pass for data
    always @(negedge select) begin
        data_out <= ~data_out;
    end

    // Arm on a rising edge, so a stray falling edge at restart skips no bit
    always @(posedge serial_clk) begin
        if (select) begin
            armed = 1'b1;
        end
    end

    // Shift on the falling edge, half a period away from the sampling point
    always @(negedge serial_clk) begin
        if (select && armed) begin
            idx = idx + 1;
            // Past bit 255 the line toggles
            data_out <= (idx < 256) ? image[idx[7:0]] : ~data_out;
        end
    end
endmodule

//--- sim/boot_mode_serial_loader_bench.sv
`timescale 1ns/1ps
`include "bmsl_consts.svh"

// One full load, then modes and register view
module boot_mode_serial_loader_bench;
    logic        aclk = 1'b0;
    logic        aresetn, supply_good_in, interface_master_role, boot_serial_data_in;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        boot_serial_clk_out, config_done, block_read_ordering, check_bus_mode;
    logic        byte_order_sel, dirty_shared_disable, no_secondary_cache, timer_irq_disable;
    logic        potential_invalidate_disable, l2_write_recovery, keep_line_on_miss;
    logic        complete_master, complete_listener, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [5:0]  l2_line_size;
    logic [3:0]  transmit_data_pattern, sys_clock_divisor, l2_write_deassert_delay;
    logic [3:0]  l2_read_cycle_time, l2_read_cycle_time_a, pipeline_clk_divisor;
    logic [1:0]  l2_write_assert_delay_b, l2_write_assert_delay_a, s_axi_bresp, s_axi_rresp;
    logic [2:0]  l2_disable_time;
    logic [255:0] img;         // Stream held by the memory model
    int          failures;    // Mismatches seen
    int          comparisons; // Checks made
    int          n;           // Cycle counter
    logic [31:0] d;           // Read data
    logic [1:0]  r;           // Response code

    // 100 MHz clock
    always #5 aclk = ~aclk;

    bmsl_loader i_dut (.*);

    bmsl_serial_mem i_mem (.serial_clk(boot_serial_clk_out), .select(supply_good_in),
        .image(img), .data_out(boot_serial_data_in));

    // Counted comparison
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Verdict and end of run
    task stop_test;
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Write: both halves offered, each released when taken
    task axi_write(input logic [11:0] a, input logic [31:0] wd, output logic [1:0] resp);
        logic done;
        begin
            done = 1'b0;
            s_axi_awaddr <= a;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata <= wd;
            s_axi_wstrb <= 4'hF;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!done) begin
                @(posedge aclk);
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid && s_axi_bready) begin
                    resp = s_axi_bresp;
                    s_axi_bready <= 1'b0;
                    done = 1'b1;
                end
            end
            // Idle edge between calls
            @(posedge aclk);
        end
    endtask

    // Read: address held until taken, rready until data arrives
    task axi_read(input logic [11:0] a, output logic [31:0] rd, output logic [1:0] resp);
        logic done;
        begin
            done = 1'b0;
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!done) begin
                @(posedge aclk);
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid && s_axi_rready) begin
                    rd = s_axi_rdata;
                    resp = s_axi_rresp;
                    s_axi_rready <= 1'b0;
                    done = 1'b1;
                end
            end
            @(posedge aclk);
        end
    endtask

    // Read a mapped register and compare the masked word
    task reg_check(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
        axi_read(a, d, r);
        check("rresp", 32'(`BMSL_RESP_OKAY), 32'(r));
        check("rdata", exp, d & mask);
    endtask

    // Boot clock: 128 cycles high, 256 cycle period
    task clk_check;
        longint t0;
        begin
            @(posedge boot_serial_clk_out);
            t0 = longint'($time);
            @(negedge boot_serial_clk_out);
            check("clk high ns", 32'd1280, 32'(longint'($time) - t0));
            @(posedge boot_serial_clk_out);
            check("clk period ns", 32'd2560, 32'(longint'($time) - t0));
        end
    endtask

    // All eight stream words, bit n at word n/32, position n%32
    task cfg_check;
        for (int i = 0; i < 8; i++) begin
            reg_check(`BMSL_OFS_CFG0 + 12'(4 * i), 32'hFFFF_FFFF, img[32 * i +: 32]);
        end
    endtask

    // Watchdog well beyond one full load
    initial begin
        repeat (80000) @(posedge aclk);
        failures++;
        stop_test();
    end

    // Main sequence
    initial begin
        failures = 0;
        comparisons = 0;
        {aresetn, supply_good_in, interface_master_role} = 3'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        // Mixed ones and zeros so a stuck field shows; reserved bits below 224 stay zero
        img = '0;
        img[255:224] = 32'hA5C3_0F96;
        img[4:0] = 5'h17;
        img[10:9] = 2'h3;
        img[14:11] = 4'h8;
        img[17:15] = 3'h3;
        img[20:19] = 2'h2;
        img[24:21] = 4'hF;
        img[28:25] = 4'hA;
        img[29] = 1'b1;
        img[32:30] = 3'h7;
        img[40:33] = 8'h53;
        img[41] = 1'b1;
        img[49:47] = 3'h2;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        clk_check();
        axi_write(12'h00C, 32'hFFFF_FFFF, r);
        check("bresp", 32'(`BMSL_RESP_SLVERR), 32'(r));
        axi_read(12'h00C, d, r);
        check("rresp", 32'(`BMSL_RESP_SLVERR), 32'(r));
        check("rdata", 32'h0, d);
        // Raise supply good while the boot clock is low
        @(negedge boot_serial_clk_out);
        @(posedge aclk);
        supply_good_in <= 1'b1;
        repeat (20) @(posedge aclk);
        reg_check(`BMSL_OFS_STATUS, 32'h600, 32'h400);
        n = 0;
        while (config_done !== 1'b1 && n < 70000) begin
            @(posedge aclk);
            n++;
        end
        // 255 or 257 bits would land a full boot period away
        check("load length", 32'h1, 32'(n >= 65280 && n <= 65536));
        repeat (2) @(posedge aclk);
        check("block_read_ordering", 32'h1, 32'(block_read_ordering));
        check("check_bus_mode", 32'h1, 32'(check_bus_mode));
        check("byte_order_sel", 32'h1, 32'(byte_order_sel));
        check("dirty_shared_disable", 32'h0, 32'(dirty_shared_disable));
        check("no_secondary_cache", 32'h1, 32'(no_secondary_cache));
        check("l2_line_size", 32'h20, 32'(l2_line_size));
        check("transmit_data_pattern", 32'h8, 32'(transmit_data_pattern));
        check("sys_clock_divisor", 32'h6, 32'(sys_clock_divisor));
        check("timer_irq_disable", 32'h0, 32'(timer_irq_disable));
        check("potential_invalidate", 32'h1, 32'(potential_invalidate_disable));
        check("write_deassert", 32'hF, 32'(l2_write_deassert_delay));
        check("write_assert_b", 32'h2, 32'(l2_write_assert_delay_b));
        check("write_assert_a", 32'h2, 32'(l2_write_assert_delay_a));
        check("l2_write_recovery", 32'h1, 32'(l2_write_recovery));
        check("l2_disable_time", 32'h7, 32'(l2_disable_time));
        check("read_cycle_b", 32'h3, 32'(l2_read_cycle_time));
        check("read_cycle_a", 32'h5, 32'(l2_read_cycle_time_a));
        check("keep_line_on_miss", 32'h1, 32'(keep_line_on_miss));
        check("complete_master", 32'h1, 32'(complete_master));
        check("complete_listener", 32'h0, 32'(complete_listener));
        check("pipeline_clk_divisor", 32'h1, 32'(pipeline_clk_divisor));
        cfg_check();
        reg_check(`BMSL_OFS_DIVS, 32'h3FFF, 32'h2061);
        // Reduced power flag selects the divisor from the stream
        axi_write(`BMSL_OFS_CTRL, 32'h2, r);
        check("bresp", 32'(`BMSL_RESP_OKAY), 32'(r));
        repeat (3) @(posedge aclk);
        check("pipeline_clk_divisor", 32'h8, 32'(pipeline_clk_divisor));
        reg_check(`BMSL_OFS_CTRL, 32'h2, 32'h2);
        axi_write(`BMSL_OFS_CTRL, 32'h0, r);
        repeat (3) @(posedge aclk);
        check("pipeline_clk_divisor", 32'h1, 32'(pipeline_clk_divisor));
        // Master pin high with stream bit clear is neither full role
        interface_master_role <= 1'b1;
        repeat (8) @(posedge aclk);
        check("complete_master", 32'h0, 32'(complete_master));
        check("complete_listener", 32'h0, 32'(complete_listener));
        reg_check(`BMSL_OFS_STATUS, 32'hA00, 32'hA00);
        // Read-only write and toggling data change nothing
        axi_write(`BMSL_OFS_CFG0, 32'h0, r);
        repeat (1024) @(posedge aclk);
        clk_check();
        cfg_check();
        check("config_done", 32'h1, 32'(config_done));
        // Supply loss clears done, modes stay
        supply_good_in <= 1'b0;
        repeat (10) @(posedge aclk);
        check("config_done", 32'h0, 32'(config_done));
        check("block_read_ordering", 32'h1, 32'(block_read_ordering));
        stop_test();
    end
endmodule
